// ===== verilog/ssc_map.svh
// register offsets, reset values, field positions and counts of the
// sync and standby control pair; definitions only
`ifndef SSC_MAP_SVH
`define SSC_MAP_SVH

// device register port offsets (8-bit address, 8-bit data)
`define SSC_PDM_OFS        8'h00
`define SSC_SPCB_OFS       8'h19
`define SSC_ORD_OFS        8'h1a

// device reset values
`define SSC_PDM_RST        8'hff
`define SSC_SPCB_RST       8'h07
`define SSC_ORD_RST        4'h1

// power_down_mask bit positions
`define SSC_PDM_BIAS       7
`define SSC_PDM_MIXOSC     6
`define SSC_PDM_OSC        5
`define SSC_PDM_SPLL       4
`define SSC_PDM_GAIN       3
`define SSC_PDM_FAMP       2
`define SSC_PDM_CONV       0

// serial_port_ctrl_b drive_level field
`define SSC_DRV_MSB        2
`define SSC_DRV_LSB        0

// samples after sync release until output is valid again
`define SSC_VALID_SAMPLES  4'hc
// serial word length in bits
`define SSC_WORD_BITS      6'h20

// host AXI4-Lite register byte offsets
`define SSC_H_CTRL_OFS     5'h00
`define SSC_H_CMD_OFS      5'h04
`define SSC_H_RDATA_OFS    5'h08
`define SSC_H_RXWORD_OFS   5'h0c
`define SSC_H_STAT_OFS     5'h10
// host command field: bit 16 = read only, no write strobe
`define SSC_H_CMD_RD       16

`endif

// ===== verilog/ssc_pkg.sv
// types shared by both ends of the sync and standby control link
// assumes ssc_map.svh carries all numeric constants
package ssc_pkg;

  // link state of the device serial port
  typedef enum logic [0:0] {
    SSC_LK_HELD = 1'b0,
    SSC_LK_RUN  = 1'b1
  } ssc_link_t;

  // complete device state
  typedef struct packed {
    logic        sync_meta;
    logic        sync_ok;
    ssc_link_t   link;
    logic [7:0]  mask;
    logic [7:0]  ctl_b;
    logic [3:0]  ord;
    logic [3:0]  div_cnt;
    logic [15:0] frame_cnt;
    logic [5:0]  bit_idx;
    logic        strobe;
    logic        marker;
    logic        sdata;
    logic [31:0] shreg;
    logic [3:0]  valid_cnt;
    logic [7:0]  rdata;
  } ssc_dev_t;

  // host AXI write channel phase
  typedef enum logic [1:0] {
    SSC_WR_IDLE = 2'b00,
    SSC_WR_RESP = 2'b01
  } ssc_wr_t;

  // complete host state
  typedef struct packed {
    ssc_wr_t     wr;
    logic        aw_got;
    logic        w_got;
    logic [4:0]  awaddr;
    logic [31:0] wdata;
    logic        rvalid;
    logic [31:0] rdata;
    logic        sync_hold;
    logic [7:0]  cmd_addr;
    logic [7:0]  cmd_data;
    logic        cmd_wr;
    logic [7:0]  dev_rdata;
    logic        prev_strobe;
    logic [31:0] rx_shift;
    logic [5:0]  rx_cnt;
    logic [31:0] rx_word;
    logic [7:0]  words;
  } ssc_host_t;

endpackage : ssc_pkg

// ===== verilog/ssc_link_if.sv
// serial output link, sync input and register port between the device
// end and the host end; one clock shared by both ends
`timescale 1ns/1ps
interface ssc_link_if;
  logic       sync_clear_n;
  logic       serial_bit_strobe;
  logic       frame_marker;
  logic       serial_data;
  logic       reg_wr;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;

  modport device (
    input  sync_clear_n, reg_wr, reg_addr, reg_wdata,
    output serial_bit_strobe, frame_marker, serial_data, reg_rdata
  );
  modport host (
    output sync_clear_n, reg_wr, reg_addr, reg_wdata,
    input  serial_bit_strobe, frame_marker, serial_data, reg_rdata
  );
endinterface : ssc_link_if

// ===== verilog/ssc_device.sv
// device end: sync handling, serial output port and standby mask
// assumes the host keeps its side of the link and mclk_i is the
// modulator clock; data_i is sampled at each frame start
//
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "ssc_map.svh"
module ssc_device #(
  parameter logic [15:0] FRAME_CLKS = 16'h0100  // modulator clocks per output sample
) (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  // link to the host
  ssc_link_if.device       link,
  // sample to transmit
  input  wire logic [31:0] data_i,
  // status towards analog logic
  output logic             modulator_reset_o,
  output logic             sample_valid_o,
  output logic [2:0]       drive_level_o,
  // standby controls
  output logic             bias_off_o,
  output logic             mixer_osc_synth_standby_o,
  output logic             osc_pump_out_oe_o,
  output logic             oscillator_standby_o,
  output logic             sampling_pll_standby_o,
  output logic             sampler_pump_out_oe_o,
  output logic             clock_buffer_off_o,
  output logic             gain_dac_standby_o,
  output logic             gain_ctl_out_oe_o,
  output logic             front_amp_mixer_standby_o,
  output logic             mixer_cap_node_oe_o,
  output logic             converter_standby_o,
  output logic             filter_clock_halt_o,
  output logic             common_mode_out_oe_o,
  output logic             master_ref_standby_o
);

  ssc_pkg::ssc_dev_t st;
  ssc_pkg::ssc_dev_t next_st;
  logic              div_wrap;
  logic              frame_start;
  logic              frozen;

  // counter wraps; divider of zero treated as one
  assign div_wrap    = (st.div_cnt + 4'h1 >= st.ord) || (st.ord == 4'h0);
  assign frame_start = (st.frame_cnt == 16'h0000);
  // converter standby halts the filter clock, outputs stay static
  assign frozen      = st.mask[`SSC_PDM_CONV];

  // next state of the whole device
  always_comb begin
    next_st = st;
    next_st.sync_meta = link.sync_clear_n;
    next_st.sync_ok   = st.sync_meta;

    if (link.reg_wr) begin
      case (link.reg_addr)
        `SSC_PDM_OFS:  next_st.mask  = link.reg_wdata;
        `SSC_SPCB_OFS: next_st.ctl_b = link.reg_wdata & 8'h8f;
        `SSC_ORD_OFS:  next_st.ord   = link.reg_wdata[3:0];
        default:       next_st.mask  = next_st.mask;
      endcase
    end

    // read data always tracks the addressed register
    case (link.reg_addr)
      `SSC_PDM_OFS:  next_st.rdata = st.mask;
      `SSC_SPCB_OFS: next_st.rdata = st.ctl_b;
      `SSC_ORD_OFS:  next_st.rdata = {4'h0, st.ord};
      default:       next_st.rdata = 8'h00;
    endcase

    case (st.link)
      ssc_pkg::SSC_LK_HELD: begin
        next_st.div_cnt   = 4'h0;
        next_st.frame_cnt = 16'h0001;  // first marker a full frame later
        next_st.bit_idx   = `SSC_WORD_BITS;
        next_st.valid_cnt = 4'h0;
        next_st.strobe    = 1'b1;
        next_st.marker    = 1'b0;
        next_st.sdata     = 1'b1;
        if (st.sync_ok) begin
          next_st.link = ssc_pkg::SSC_LK_RUN;
        end
      end
      ssc_pkg::SSC_LK_RUN: begin
        if (!st.sync_ok) begin
          next_st.link      = ssc_pkg::SSC_LK_HELD;
          next_st.div_cnt   = 4'h0;
          next_st.frame_cnt = 16'h0001;
          next_st.valid_cnt = 4'h0;
          next_st.strobe    = 1'b1;
          next_st.marker    = 1'b0;
          next_st.sdata     = 1'b1;
        end else if (!frozen) begin
          if (st.frame_cnt + 16'h0001 >= FRAME_CLKS) begin
            next_st.frame_cnt = 16'h0000;
          end else begin
            next_st.frame_cnt = st.frame_cnt + 16'h0001;
          end
          if (frame_start) begin
            // new sample: marker for one bit period, first bit out
            next_st.shreg   = {data_i[30:0], 1'b1};
            next_st.sdata   = data_i[31];
            next_st.bit_idx = 6'h01;
            next_st.marker  = 1'b1;
            next_st.strobe  = 1'b1;
            next_st.div_cnt = 4'h0;
            // valid from the twelfth sample on
            if (st.valid_cnt != `SSC_VALID_SAMPLES) begin
              next_st.valid_cnt = st.valid_cnt + 4'h1;
            end
          end else if (div_wrap) begin
            // strobe toggles one divider period after release
            next_st.div_cnt = 4'h0;
            next_st.strobe  = ~st.strobe;
            if (!st.strobe) begin
              // rising strobe starts the next bit; idle bits high
              next_st.marker = 1'b0;
              if (st.bit_idx < `SSC_WORD_BITS) begin
                next_st.sdata   = st.shreg[31];
                next_st.shreg   = {st.shreg[30:0], 1'b1};
                next_st.bit_idx = st.bit_idx + 6'h01;
              end else begin
                next_st.sdata = 1'b1;
              end
            end
          end else begin
            next_st.div_cnt = st.div_cnt + 4'h1;
          end
        end
      end
      default: begin
        next_st.link = ssc_pkg::SSC_LK_HELD;
      end
    endcase
  end

  // state register
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      st           <= '0;
      st.mask      <= `SSC_PDM_RST;
      st.ctl_b     <= `SSC_SPCB_RST;
      st.ord       <= `SSC_ORD_RST;
      st.frame_cnt <= 16'h0001;
      st.bit_idx   <= `SSC_WORD_BITS;
      st.strobe    <= 1'b1;
      st.sdata     <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // link outputs straight from flops
  assign link.serial_bit_strobe = st.strobe;
  assign link.frame_marker      = st.marker;
  assign link.serial_data       = st.sdata;
  assign link.reg_rdata         = st.rdata;

  // no synthesizer counter lives here, sync cannot reach one
  assign modulator_reset_o = (st.link == ssc_pkg::SSC_LK_HELD);
  assign sample_valid_o    = (st.valid_cnt == `SSC_VALID_SAMPLES);
  assign drive_level_o     = st.ctl_b[`SSC_DRV_MSB:`SSC_DRV_LSB];

  assign bias_off_o                = st.mask[`SSC_PDM_BIAS];
  assign mixer_osc_synth_standby_o = st.mask[`SSC_PDM_MIXOSC];
  assign osc_pump_out_oe_o         = ~st.mask[`SSC_PDM_MIXOSC];
  assign oscillator_standby_o      = st.mask[`SSC_PDM_OSC];
  assign sampling_pll_standby_o    = st.mask[`SSC_PDM_SPLL];
  assign sampler_pump_out_oe_o     = ~st.mask[`SSC_PDM_SPLL];
  // buffer off only when both users are down
  assign clock_buffer_off_o        = st.mask[`SSC_PDM_SPLL] & st.mask[`SSC_PDM_CONV];
  // gain DAC and its gain control output enable
  assign gain_dac_standby_o        = st.mask[`SSC_PDM_GAIN];
  assign gain_ctl_out_oe_o         = ~st.mask[`SSC_PDM_GAIN];
  assign front_amp_mixer_standby_o = st.mask[`SSC_PDM_FAMP];
  assign mixer_cap_node_oe_o       = ~st.mask[`SSC_PDM_FAMP];
  assign converter_standby_o       = st.mask[`SSC_PDM_CONV];
  assign filter_clock_halt_o       = st.mask[`SSC_PDM_CONV];
  assign common_mode_out_oe_o      = ~st.mask[`SSC_PDM_CONV];
  // unused bit 1 does not count as a block
  assign master_ref_standby_o      = &{st.mask[7:2], st.mask[0]};

endmodule : ssc_device

// ===== verilog/ssc_host.sv
// host end: AXI4-Lite slave for software, drives sync and the device
// register port, and deserialises the serial output
// assumes the same clock as the device end
`timescale 1ns/1ps
`include "ssc_map.svh"
module ssc_host (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  // AXI4-Lite write
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [4:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  // AXI4-Lite read
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [4:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  // link to the device
  ssc_link_if.host         link
);

  ssc_pkg::ssc_host_t st;
  ssc_pkg::ssc_host_t next_st;
  logic               strobe_fall;
  logic [31:0]        rd_mux;

  // samples taken on falling strobe, mid bit
  assign strobe_fall = st.prev_strobe & ~link.serial_bit_strobe;

  // read decode; unmapped offsets read zero
  always_comb begin
    case (araddr)
      `SSC_H_CTRL_OFS:   rd_mux = {31'h0, st.sync_hold};
      `SSC_H_CMD_OFS:    rd_mux = {16'h0, st.cmd_addr, st.cmd_data};
      `SSC_H_RDATA_OFS:  rd_mux = {24'h0, st.dev_rdata};
      `SSC_H_RXWORD_OFS: rd_mux = st.rx_word;
      `SSC_H_STAT_OFS:   rd_mux = {24'h0, st.words};
      default:           rd_mux = 32'h0;
    endcase
  end

  // next state of the whole host
  always_comb begin
    next_st = st;
    next_st.cmd_wr      = 1'b0;
    next_st.dev_rdata   = link.reg_rdata;
    next_st.prev_strobe = link.serial_bit_strobe;
    // capture address and data in either order
    if (awvalid && awready) begin
      next_st.aw_got = 1'b1;
      next_st.awaddr = awaddr;
    end
    if (wvalid && wready) begin
      next_st.w_got = 1'b1;
      next_st.wdata = wdata;
    end
    case (st.wr)
      ssc_pkg::SSC_WR_IDLE: begin
        if (next_st.aw_got && next_st.w_got) begin
          next_st.wr     = ssc_pkg::SSC_WR_RESP;
          next_st.aw_got = 1'b0;
          next_st.w_got  = 1'b0;
          case (next_st.awaddr)
            // software releases sync only after tuning
            `SSC_H_CTRL_OFS: next_st.sync_hold = next_st.wdata[0];
            // zero wakes a block, one parks it
            `SSC_H_CMD_OFS: begin
              next_st.cmd_data = next_st.wdata[7:0];
              next_st.cmd_addr = next_st.wdata[15:8];
              next_st.cmd_wr   = ~next_st.wdata[`SSC_H_CMD_RD];
            end
            default: next_st.sync_hold = st.sync_hold;
          endcase
        end
      end
      ssc_pkg::SSC_WR_RESP: begin
        if (bready) begin
          next_st.wr = ssc_pkg::SSC_WR_IDLE;
        end
      end
      default: next_st.wr = ssc_pkg::SSC_WR_IDLE;
    endcase
    // read channel
    if (arvalid && arready) begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = rd_mux;
    end else if (st.rvalid && rready) begin
      next_st.rvalid = 1'b0;
    end
    // frame marker restarts word; sync hold clears word count
    if (st.sync_hold) begin
      next_st.rx_cnt = 6'h00;
      next_st.words  = 8'h00;
    end else if (strobe_fall) begin
      if (link.frame_marker) begin
        next_st.rx_shift = {31'h0, link.serial_data};
        next_st.rx_cnt   = 6'h01;
      end else if (st.rx_cnt != 6'h00 && st.rx_cnt < `SSC_WORD_BITS) begin
        next_st.rx_shift = {st.rx_shift[30:0], link.serial_data};
        next_st.rx_cnt   = st.rx_cnt + 6'h01;
        if (st.rx_cnt + 6'h01 == `SSC_WORD_BITS) begin
          next_st.rx_word = {st.rx_shift[30:0], link.serial_data};
          if (st.words != 8'hff) begin
            next_st.words = st.words + 8'h01;
          end
        end
      end
    end
  end

  // state register
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      st             <= '0;
      st.sync_hold   <= 1'b1;  // device held until software releases
      st.prev_strobe <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // handshakes; strobes unused, every write takes the whole data word
  assign awready = ~st.aw_got & (st.wr == ssc_pkg::SSC_WR_IDLE);
  assign wready  = ~st.w_got & (st.wr == ssc_pkg::SSC_WR_IDLE);
  assign bvalid  = (st.wr == ssc_pkg::SSC_WR_RESP);
  assign bresp   = 2'b00;
  assign arready = ~st.rvalid;
  assign rvalid  = st.rvalid;
  assign rdata   = st.rdata;
  assign rresp   = 2'b00;

  // sync from a flop, whole clocks, fixed timing
  assign link.sync_clear_n = ~st.sync_hold;
  assign link.reg_wr       = st.cmd_wr;
  assign link.reg_addr     = st.cmd_addr;
  assign link.reg_wdata    = st.cmd_data;

endmodule : ssc_host

// ===== tb/ssc_link_props.sv
// checker for the serial link and register port between the two ends
// assumes one clock shared by both ends; sees interface signals only
`timescale 1ns/1ps
`include "ssc_map.svh"
module ssc_link_props (
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       reset_i,
  // serial link
  input  wire logic       sync_clear_n,
  input  wire logic       serial_bit_strobe,
  input  wire logic       frame_marker,
  input  wire logic       serial_data,
  // register port
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  logic [7:0] sh_mask;
  logic [7:0] sh_ctl;
  logic [3:0] sh_ord;
  logic [4:0] mk_cnt;
  logic [4:0] mk_len;
  logic [7:0] exp_rd;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  // shadow of the device registers, follows every port write
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      sh_mask <= `SSC_PDM_RST;
      sh_ctl  <= `SSC_SPCB_RST;
      sh_ord  <= `SSC_ORD_RST;
    end else if (reg_wr) begin
      if (reg_addr == `SSC_PDM_OFS) sh_mask <= reg_wdata;
      if (reg_addr == `SSC_SPCB_OFS) sh_ctl <= reg_wdata & 8'h8f;
      if (reg_addr == `SSC_ORD_OFS) sh_ord <= reg_wdata[3:0];
    end
  end

  // marker length; cleared while frozen so a stall never counts
  always_ff @(posedge mclk_i) begin
    if (reset_i || !frame_marker || sh_mask[0]) mk_cnt <= 5'h00;
    else mk_cnt <= mk_cnt + 5'h01;
  end

  // expected read-back, and marker length (divider 0 acts as 1)
  always_comb begin
    mk_len = (sh_ord == 4'h0) ? 5'h02 : {sh_ord, 1'b0};
    case (reg_addr)
      `SSC_PDM_OFS:  exp_rd = sh_mask;
      `SSC_SPCB_OFS: exp_rd = sh_ctl;
      `SSC_ORD_OFS:  exp_rd = {4'h0, sh_ord};
      default:       exp_rd = 8'h00;
    endcase
  end

  sequence s_held;
    !sync_clear_n [*4];
  endsequence
  sequence s_release;
    $rose(sync_clear_n) && !sh_mask[0];
  endsequence
  sequence s_restart;
    serial_bit_strobe [*2] ##[1:40] $fell(serial_bit_strobe);
  endsequence

  property p_held;
    s_held |-> serial_bit_strobe && !frame_marker && serial_data;
  endproperty
  property p_restart;
    s_release |-> s_restart;
  endproperty
  property p_marker_start;
    $rose(frame_marker) |-> serial_bit_strobe;
  endproperty
  property p_marker_width;
    $fell(frame_marker) && sync_clear_n && !sh_mask[0] |-> mk_cnt == mk_len;
  endproperty
  property p_rdata;
    !$past(reset_i) |-> reg_rdata == $past(exp_rd);
  endproperty
  property p_wr_pulse;
    reg_wr |=> !reg_wr;
  endproperty
  property p_reset_idle;
    $fell(reset_i) |-> serial_bit_strobe && !frame_marker && serial_data && !sync_clear_n;
  endproperty
  property p_freeze;
    sh_mask[0] && $past(sh_mask[0]) && $past(sh_mask[0], 2) && sync_clear_n && $past(sync_clear_n, 3)
      |-> $stable(serial_bit_strobe) && $stable(frame_marker) && $stable(serial_data);
  endproperty

  a_held: assert property (p_held) else $error("strobe or marker not held during sync");
  a_restart: assert property (p_restart) else $error("strobe restart out of window");
  a_marker_start: assert property (p_marker_start) else $error("marker rose with strobe low");
  a_marker_width: assert property (p_marker_width) else $error("marker width wrong");
  a_rdata: assert property (p_rdata) else $error("register read-back wrong");
  a_wr_pulse: assert property (p_wr_pulse) else $error("register write longer than one cycle");
  a_reset_idle: assert property (p_reset_idle) else $error("link not idle after reset");
  a_freeze: assert property (p_freeze) else $error("outputs moved while converter frozen");
endmodule : ssc_link_props

// ===== tb/tb_sync_and_standby_control.sv
// testbench for the device end and host end joined by the link
// assumes one 250 MHz clock; software side driven as AXI4-Lite master
`timescale 1ns/1ps
`include "ssc_map.svh"
module tb_sync_and_standby_control;
  localparam logic [31:0] DATA = 32'h5ac396e1;
  logic        mclk_i;
  logic        reset_i;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [4:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic        modulator_reset_o, sample_valid_o;
  logic [2:0]  drive_level_o;
  logic [14:0] sb;
  int          err_total, tests_run;

  ssc_link_if ssc_link_if_inst ();
  ssc_device #(.FRAME_CLKS(16'h0050)) ssc_device_inst (
    .mclk_i(mclk_i), .reset_i(reset_i), .link(ssc_link_if_inst), .data_i(DATA),
    .modulator_reset_o(modulator_reset_o), .sample_valid_o(sample_valid_o), .drive_level_o(drive_level_o),
    .bias_off_o(sb[14]), .mixer_osc_synth_standby_o(sb[13]), .osc_pump_out_oe_o(sb[12]),
    .oscillator_standby_o(sb[11]), .sampling_pll_standby_o(sb[10]), .sampler_pump_out_oe_o(sb[9]),
    .clock_buffer_off_o(sb[8]), .gain_dac_standby_o(sb[7]), .gain_ctl_out_oe_o(sb[6]),
    .front_amp_mixer_standby_o(sb[5]), .mixer_cap_node_oe_o(sb[4]), .converter_standby_o(sb[3]),
    .filter_clock_halt_o(sb[2]), .common_mode_out_oe_o(sb[1]), .master_ref_standby_o(sb[0]));
  ssc_host ssc_host_inst (
    .mclk_i(mclk_i), .reset_i(reset_i), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .link(ssc_link_if_inst));
  ssc_link_props ssc_link_props_inst (
    .mclk_i(mclk_i), .reset_i(reset_i), .sync_clear_n(ssc_link_if_inst.sync_clear_n),
    .serial_bit_strobe(ssc_link_if_inst.serial_bit_strobe), .frame_marker(ssc_link_if_inst.frame_marker),
    .serial_data(ssc_link_if_inst.serial_data), .reg_wr(ssc_link_if_inst.reg_wr),
    .reg_addr(ssc_link_if_inst.reg_addr), .reg_wdata(ssc_link_if_inst.reg_wdata),
    .reg_rdata(ssc_link_if_inst.reg_rdata));

  // free-running clock, 4 ns period
  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic end_of_test();
    if (err_total == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  // both channels offered together, each dropped when taken
  // handshakes judged on settled values just before each edge
  task automatic axi_write(input logic [4:0] a, input logic [31:0] d);
    int n;
    logic aw_hs, w_hs, b_hs;
    n = 0;
    @(posedge mclk_i);
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; bready <= 1'b1;
    do begin
      #1;
      aw_hs = awvalid && awready === 1'b1;
      w_hs = wvalid && wready === 1'b1;
      b_hs = bvalid === 1'b1;
      @(posedge mclk_i);
      n++;
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
      if (b_hs) bready <= 1'b0;
    end while (!b_hs && n < 200);
    chk({b_hs, bresp}, 3'b100);
  endtask : axi_write

  task automatic axi_read(input logic [4:0] a, output logic [31:0] d);
    int n;
    logic ar_hs, r_hs;
    n = 0;
    d = 32'hdead0bad;
    @(posedge mclk_i);
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    do begin
      #1;
      ar_hs = arvalid && arready === 1'b1;
      r_hs = rvalid === 1'b1;
      if (r_hs) d = rdata;
      @(posedge mclk_i);
      n++;
      if (ar_hs) arvalid <= 1'b0;
      if (r_hs) rready <= 1'b0;
    end while (!r_hs && n < 200);
    chk({r_hs, rresp}, 3'b100);
  endtask : axi_read

  // device register access through the host command word
  task automatic dev_wr(input logic [7:0] a, input logic [7:0] d);
    axi_write(`SSC_H_CMD_OFS, {16'h0000, a, d});
    repeat (3) @(posedge mclk_i);
    #1;
  endtask : dev_wr

  task automatic dev_rd(input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] r;
    axi_write(`SSC_H_CMD_OFS, {15'h0000, 1'b1, a, 8'h00});
    repeat (4) @(posedge mclk_i);
    axi_read(`SSC_H_RDATA_OFS, r);
    chk(r, {24'h0, exp});
  endtask : dev_rd

  function automatic logic [14:0] sb_exp(input logic [7:0] m);
    return {m[7], m[6], ~m[6], m[5], m[4], ~m[4], m[4] & m[0], m[3], ~m[3], m[2], ~m[2],
            m[0], m[0], ~m[0], &{m[7:2], m[0]}};
  endfunction : sb_exp

  // counts marker rises, bounded
  task automatic wait_frames(input int n);
    int c;
    for (int i = 0; i < n; i++) begin
      c = 0;
      while (ssc_link_if_inst.frame_marker === 1'b1 && c < 1000) begin @(posedge mclk_i); #1; c++; end
      while (ssc_link_if_inst.frame_marker !== 1'b1 && c < 1000) begin @(posedge mclk_i); #1; c++; end
    end
  endtask : wait_frames

  task automatic release_sync(output int d);
    axi_write(`SSC_H_CTRL_OFS, 32'h0);
    d = 0;
    while (ssc_link_if_inst.frame_marker !== 1'b1 && d < 1000) begin @(posedge mclk_i); #1; d++; end
  endtask : release_sync

  task automatic t_reset();
    @(posedge mclk_i);
    #1;
    chk(sb, sb_exp(8'hff));
    chk(drive_level_o, 3'h7);
    dev_rd(`SSC_PDM_OFS, 8'hff);
    dev_rd(`SSC_SPCB_OFS, 8'h07);
  endtask : t_reset

  // every drive code, reserved bits, divider, unmapped places
  task automatic t_regs();
    logic [31:0] r;
    for (int i = 0; i < 8; i++) begin
      dev_wr(`SSC_SPCB_OFS, 8'hf0 | i[7:0]);
      chk(drive_level_o, i[2:0]);
    end
    dev_rd(`SSC_SPCB_OFS, 8'h87);
    dev_wr(`SSC_SPCB_OFS, 8'h00);
    chk(drive_level_o, 3'h0);
    dev_wr(`SSC_ORD_OFS, 8'hf3);
    dev_rd(`SSC_ORD_OFS, 8'h03);
    dev_wr(`SSC_ORD_OFS, 8'h01);
    dev_wr(8'h05, 8'h55);
    dev_rd(8'h05, 8'h00);
    axi_read(5'h14, r);
    chk(r, 32'h0);
  endtask : t_regs

  // one block at a time, one pair, and the unused bit
  task automatic t_mask();
    logic [7:0] m [11];
    m = '{8'h7f, 8'hbf, 8'hdf, 8'hef, 8'hf7, 8'hfb, 8'hfe, 8'hee, 8'hfd, 8'hff, 8'h00};
    foreach (m[i]) begin
      dev_wr(`SSC_PDM_OFS, m[i]);
      chk(sb, sb_exp(m[i]));
    end
    dev_rd(`SSC_PDM_OFS, 8'h00);
  endtask : t_mask

  task automatic t_sync();
    int d1, d2;
    logic [31:0] r;
    release_sync(d1);
    chk(ssc_link_if_inst.serial_data, DATA[31]);
    chk(d1 < 200, 1'b1);
    #1;
    chk(modulator_reset_o, 1'b0);
    wait_frames(10);
    #1;
    chk(sample_valid_o, 1'b0);
    wait_frames(1);
    repeat (3) @(posedge mclk_i);
    #1;
    chk(sample_valid_o, 1'b1);
    axi_read(`SSC_H_RXWORD_OFS, r);
    chk(r, DATA);
    axi_read(`SSC_H_STAT_OFS, r);
    chk(r, 32'h0000000b);
    axi_write(`SSC_H_CTRL_OFS, 32'h1);
    repeat (10) @(posedge mclk_i);
    #1;
    chk({modulator_reset_o, sample_valid_o}, 2'b10);
    chk({ssc_link_if_inst.serial_bit_strobe, ssc_link_if_inst.frame_marker}, 2'b10);
    release_sync(d2);
    chk(d2, d1);
  endtask : t_sync

  task automatic t_freeze();
    logic [2:0] s;
    dev_wr(`SSC_PDM_OFS, 8'h01);
    s = {ssc_link_if_inst.serial_bit_strobe, ssc_link_if_inst.frame_marker, ssc_link_if_inst.serial_data};
    repeat (20) @(posedge mclk_i);
    #1;
    chk({ssc_link_if_inst.serial_bit_strobe, ssc_link_if_inst.frame_marker, ssc_link_if_inst.serial_data}, s);
  endtask : t_freeze

  // main sequence; reset held four cycles
  initial begin
    err_total = 0;
    tests_run = 0;
    reset_i = 1'b1;
    awvalid = 1'b0; awaddr = 5'h00; wvalid = 1'b0; wdata = 32'h0; bready = 1'b0;
    arvalid = 1'b0; araddr = 5'h00; rready = 1'b0;
    repeat (4) @(posedge mclk_i);
    reset_i <= 1'b0;
    t_reset();
    t_regs();
    t_mask();
    t_sync();
    t_freeze();
    end_of_test();
  end

  // watchdog well beyond the expected run of about 1300 cycles
  initial begin
    #200000;
    err_total++;
    end_of_test();
  end
endmodule : tb_sync_and_standby_control
